// file: rtl/hpt_engine.v
// Purpose: Fire control, sequencer walk and segment time adjust of the playback engine
// Assumes: Register port and waveform library are synchronous to i_clk
// Notes:   Calibration and diagnostic routines live outside; this block starts them
//
// Behaviour
// - Fire bit launches process chosen by mode
// - Sequence mode fire plays up to the eight slots, from slot zero
// - Fire bit reads one until sequence ends
// - Host clearing fire bit aborts playback outside the external modes
// - External modes let trigger pin drive fire
// - Calibration or diagnostic mode starts that routine
// - Overdrive length adjusted by field times base
// - Overdrive segment is the peak-amplitude portion
// - Overdrive adjust applies in open loop only
// - Overdrive adjust is two's complement
// - Positive sustain adjusted by field times base
// - Other positive samples count as positive sustain
// - Positive sustain adjust is two's complement
// - Slots play in order, stop at zero
// - Wait slot idles value times ten ms
`timescale 1ns/1ps
`default_nettype none
`include "hpt_regs.vh"

module hpt_engine #(
  parameter MS_CYCLES = `HPT_MS_NS / `HPT_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // Register port
  input  wire [7:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output wire [7:0]  o_reg_rdata,
  // Configuration levels
  input  wire [2:0]  i_mode,
  input  wire        i_closed_loop,
  input  wire        i_time_base_long,
  // External trigger pin
  input  wire        i_trig,
  // Waveform library
  output reg         o_wave_req,
  output reg  [6:0]  o_wave_id,
  input  wire [7:0]  i_wave_peak,
  input  wire        i_seg_valid,
  input  wire [7:0]  i_seg_amp,
  input  wire [7:0]  i_seg_dur,
  input  wire        i_seg_last,
  output wire        o_seg_ready,
  // Drive output
  output reg  [7:0]  o_drive_amp,
  output reg         o_drive_active,
  // Calibration and diagnostic routines
  output reg         o_cal_start,
  output reg         o_diag_start,
  input  wire        i_proc_done,
  // Status
  output wire        o_busy
);

  // ****************************************
  // State and storage
  // ****************************************
  localparam S_IDLE = 3'h0;
  localparam S_RD   = 3'h1;
  localparam S_DEC  = 3'h2;
  localparam S_SEG  = 3'h3;
  localparam S_PLAY = 3'h4;
  localparam S_PROC = 3'h5;
  localparam MSW    = $clog2(MS_CYCLES + 1);

  reg  [2:0]     state_reg;
  reg  [2:0]     state_next;
  reg            fire_reg;
  reg            fire_next;
  reg  [7:0]     od_adj_reg;
  reg  [7:0]     ps_adj_reg;
  reg            trig_prev_reg;
  reg  [2:0]     slot_idx_reg;
  reg  [2:0]     slot_idx_next;
  reg            seg_last_reg;
  reg            seg_last_next;
  reg  [9:0]     units_reg;
  reg  [9:0]     units_next;
  reg  [3:0]     base_ms_reg;
  reg  [3:0]     base_ms_next;
  reg  [3:0]     ms_left_reg;
  reg  [3:0]     ms_left_next;
  reg  [MSW-1:0] cyc_reg;
  reg  [MSW-1:0] cyc_next;
  reg            done;
  reg            wave_req_next;
  reg  [6:0]     wave_id_next;
  reg  [7:0]     drive_amp_next;
  reg            drive_active_next;
  reg            cal_start_next;
  reg            diag_start_next;
  reg  [7:0]     rdata_reg;
  reg            rd_slot_reg;
  reg  [2:0]     slot_rd_addr_reg;
  wire [7:0]     slot_data;
  wire [7:0]     slot_rdata;

  wire ext_mode   = (i_mode == `HPT_MODE_EXT_EDGE) || (i_mode == `HPT_MODE_EXT_LEVEL);
  wire seq_mode   = (i_mode == `HPT_MODE_INT_TRIG) || ext_mode;
  wire slot_hit   = (i_reg_addr >= `HPT_ADDR_SLOT_FIRST) && (i_reg_addr <= `HPT_ADDR_SLOT_LAST);
  wire [7:0] slot_off = i_reg_addr - `HPT_ADDR_SLOT_FIRST;
  wire fire_wr    = i_reg_wr && (i_reg_addr == `HPT_ADDR_FIRE);
  wire trig_rise  = i_trig && !trig_prev_reg;
  wire trig_fall  = !i_trig && trig_prev_reg;
  // Slot read address held between reads so read data stands until the next read or a write to that slot
  wire [2:0] slot_raddr_b = i_reg_rd ? slot_off[2:0] : slot_rd_addr_reg;

  // ****************************************
  // Sequencer slots
  // ****************************************
  hpt_slot_mem #(
    .WIDTH (8),
    .DEPTH (`HPT_SLOT_COUNT),
    .AW    (3)
  ) u_slots (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_wr      (i_reg_wr && slot_hit),
    .i_waddr   (slot_off[2:0]),
    .i_wdata   (i_reg_wdata),
    .i_raddr_a (slot_idx_reg),
    .o_rdata_a (slot_data),
    .i_raddr_b (slot_raddr_b),
    .o_rdata_b (slot_rdata)
  );

  // ****************************************
  // Segment classification and adjust
  // ****************************************
  wire       is_od     = (i_seg_amp == i_wave_peak) && !i_seg_amp[7] && (i_seg_amp != 8'h00);
  wire       is_ps     = !i_seg_amp[7] && (i_seg_amp != 8'h00) && !is_od;
  wire [9:0] od_off    = {{2{od_adj_reg[7]}}, od_adj_reg};
  wire [9:0] ps_off    = {{2{ps_adj_reg[7]}}, ps_adj_reg};
  wire [9:0] seg_off   = (is_od && !i_closed_loop) ? od_off :
                         is_ps ? ps_off : 10'h000;
  wire [9:0] adj_sum   = {2'b00, i_seg_dur} + seg_off;
  wire [9:0] adj_units = adj_sum[9] ? 10'h000 : adj_sum;
  wire [3:0] tb_ms     = i_time_base_long ? `HPT_BASE_LONG_MS : `HPT_BASE_SHORT_MS;

  assign o_seg_ready = (state_reg == S_SEG);
  assign o_busy      = (state_reg != S_IDLE);

  // ****************************************
  // Fire bit
  // ****************************************
  always @* begin
    fire_next = fire_reg;
    if (done) begin
      fire_next = 1'b0;
    end
    if (fire_wr && !ext_mode) begin
      fire_next = i_reg_wdata[`HPT_FIRE_BIT];
    end
    // Pin writes last so a trigger edge beats a completion clear
    if (i_mode == `HPT_MODE_EXT_EDGE && trig_rise) begin
      fire_next = 1'b1;
    end
    if (i_mode == `HPT_MODE_EXT_LEVEL) begin
      if (trig_rise) begin
        fire_next = 1'b1;
      end else if (trig_fall) begin
        fire_next = 1'b0;
      end
    end
  end

  // ****************************************
  // Engine sequence
  // ****************************************
  always @* begin
    state_next        = state_reg;
    slot_idx_next     = slot_idx_reg;
    seg_last_next     = seg_last_reg;
    units_next        = units_reg;
    base_ms_next      = base_ms_reg;
    ms_left_next      = ms_left_reg;
    cyc_next          = cyc_reg;
    done              = 1'b0;
    wave_req_next     = 1'b0;
    wave_id_next      = o_wave_id;
    drive_amp_next    = o_drive_amp;
    drive_active_next = o_drive_active;
    cal_start_next    = 1'b0;
    diag_start_next   = 1'b0;
    case (state_reg)
      S_IDLE: begin
        drive_active_next = 1'b0;
        drive_amp_next    = 8'h00;
        if (fire_reg) begin
          if (seq_mode) begin
            slot_idx_next = 3'h0;
            state_next    = S_RD;
          end else if (i_mode == `HPT_MODE_CAL) begin
            cal_start_next = 1'b1;
            state_next     = S_PROC;
          end else if (i_mode == `HPT_MODE_DIAG) begin
            diag_start_next = 1'b1;
            state_next      = S_PROC;
          end else begin
            // No process behind this mode: drop the bit at once
            done = 1'b1;
          end
        end
      end
      S_RD: begin
        state_next = S_DEC;
      end
      S_DEC: begin
        if (slot_data == 8'h00) begin
          done       = 1'b1;
          state_next = S_IDLE;
        end else if (slot_data[`HPT_SLOT_WAIT_BIT]) begin
          units_next        = {3'b000, slot_data[6:0]};
          base_ms_next      = `HPT_WAIT_UNIT_MS;
          ms_left_next      = `HPT_WAIT_UNIT_MS;
          cyc_next          = {MSW{1'b0}};
          seg_last_next     = 1'b1;
          drive_amp_next    = 8'h00;
          drive_active_next = 1'b0;
          state_next        = S_PLAY;
        end else begin
          wave_req_next = 1'b1;
          wave_id_next  = slot_data[6:0];
          state_next    = S_SEG;
        end
      end
      S_SEG: begin
        if (i_seg_valid) begin
          units_next        = adj_units;
          base_ms_next      = tb_ms;
          ms_left_next      = tb_ms;
          cyc_next          = {MSW{1'b0}};
          seg_last_next     = i_seg_last;
          drive_amp_next    = i_seg_amp;
          drive_active_next = 1'b1;
          state_next        = S_PLAY;
        end
      end
      S_PLAY: begin
        if (units_reg == 10'h000) begin
          if (!seg_last_reg) begin
            state_next = S_SEG;
          end else if (slot_idx_reg == 3'h7) begin
            done       = 1'b1;
            state_next = S_IDLE;
          end else begin
            slot_idx_next = slot_idx_reg + 3'h1;
            state_next    = S_RD;
          end
          drive_active_next = 1'b0;
          drive_amp_next    = 8'h00;
        end else if (cyc_reg == MS_CYCLES[MSW-1:0] - {{(MSW-1){1'b0}}, 1'b1}) begin
          cyc_next = {MSW{1'b0}};
          if (ms_left_reg == 4'h1) begin
            ms_left_next = base_ms_reg;
            units_next   = units_reg - 10'h001;
          end else begin
            ms_left_next = ms_left_reg - 4'h1;
          end
        end else begin
          cyc_next = cyc_reg + {{(MSW-1){1'b0}}, 1'b1};
        end
      end
      S_PROC: begin
        if (i_proc_done) begin
          done       = 1'b1;
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // Fire bit cleared by the host or pin: cancel whatever runs
    if (state_reg != S_IDLE && !fire_reg) begin
      state_next        = S_IDLE;
      done              = 1'b0;
      wave_req_next     = 1'b0;
      drive_active_next = 1'b0;
      drive_amp_next    = 8'h00;
    end
  end

  // ****************************************
  // Registers and read port
  // ****************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      state_reg      <= S_IDLE;
      fire_reg       <= 1'b0;
      od_adj_reg     <= `HPT_OD_ADJ_RST;
      ps_adj_reg     <= `HPT_PS_ADJ_RST;
      trig_prev_reg  <= 1'b0;
      slot_idx_reg   <= 3'h0;
      seg_last_reg   <= 1'b0;
      units_reg      <= 10'h000;
      base_ms_reg    <= `HPT_BASE_SHORT_MS;
      ms_left_reg    <= `HPT_BASE_SHORT_MS;
      cyc_reg        <= {MSW{1'b0}};
      o_wave_req     <= 1'b0;
      o_wave_id      <= 7'h00;
      o_drive_amp    <= 8'h00;
      o_drive_active <= 1'b0;
      o_cal_start    <= 1'b0;
      o_diag_start   <= 1'b0;
      rdata_reg      <= 8'h00;
      rd_slot_reg    <= 1'b0;
      slot_rd_addr_reg <= 3'h0;
    end else begin
      state_reg      <= state_next;
      fire_reg       <= fire_next;
      trig_prev_reg  <= i_trig;
      slot_idx_reg   <= slot_idx_next;
      seg_last_reg   <= seg_last_next;
      units_reg      <= units_next;
      base_ms_reg    <= base_ms_next;
      ms_left_reg    <= ms_left_next;
      cyc_reg        <= cyc_next;
      o_wave_req     <= wave_req_next;
      o_wave_id      <= wave_id_next;
      o_drive_amp    <= drive_amp_next;
      o_drive_active <= drive_active_next;
      o_cal_start    <= cal_start_next;
      o_diag_start   <= diag_start_next;
      if (i_reg_wr && i_reg_addr == `HPT_ADDR_OD_ADJ) begin
        od_adj_reg <= i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == `HPT_ADDR_PS_ADJ) begin
        ps_adj_reg <= i_reg_wdata;
      end
      if (i_reg_rd) begin
        rd_slot_reg <= slot_hit;
        slot_rd_addr_reg <= slot_off[2:0];
        case (i_reg_addr)
          `HPT_ADDR_FIRE:   rdata_reg <= {7'h00, fire_reg};
          `HPT_ADDR_OD_ADJ: rdata_reg <= od_adj_reg;
          `HPT_ADDR_PS_ADJ: rdata_reg <= ps_adj_reg;
          default:          rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  // Slot reads come from the memory's own output flop
  assign o_reg_rdata = rd_slot_reg ? slot_rdata : rdata_reg;

endmodule

`default_nettype wire

// file: rtl/hpt_regs.vh
// Purpose: Constants for the haptic playback trigger and timing block
// Assumes: 10 MHz system clock
// Notes:   Offsets are byte addresses on the device register port
`ifndef HPT_REGS_VH
`define HPT_REGS_VH

// Register offsets
`define HPT_ADDR_SLOT_FIRST   8'h04
`define HPT_ADDR_SLOT_LAST    8'h0b
`define HPT_ADDR_FIRE         8'h0c
`define HPT_ADDR_OD_ADJ       8'h0d
`define HPT_ADDR_PS_ADJ       8'h0e

// Field positions and reset values
`define HPT_FIRE_BIT          0
`define HPT_SLOT_WAIT_BIT     7
`define HPT_FIRE_RST          8'h00
`define HPT_OD_ADJ_RST        8'h00
`define HPT_PS_ADJ_RST        8'h00
`define HPT_SLOT_RST          8'h00
`define HPT_SLOT_COUNT        8

// Mode field encodings
`define HPT_MODE_INT_TRIG     3'h0
`define HPT_MODE_EXT_EDGE     3'h1
`define HPT_MODE_EXT_LEVEL    3'h2
`define HPT_MODE_DIAG         3'h6
`define HPT_MODE_CAL          3'h7

// Timing
`define HPT_CLK_PERIOD_NS     100
`define HPT_MS_NS             1000000
`define HPT_WAIT_UNIT_MS      4'ha
`define HPT_BASE_SHORT_MS     4'h1
`define HPT_BASE_LONG_MS      4'h5

`endif

// file: rtl/hpt_slot_mem.v
// Purpose: Sequencer slot storage with two registered read ports
// Assumes: Single clock, synchronous active-high reset
// Notes:   Slots clear to zero at reset so an idle sequence is empty
`timescale 1ns/1ps
`default_nettype none

module hpt_slot_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst,
  // Write port
  input  wire             i_wr,
  input  wire [AW-1:0]    i_waddr,
  input  wire [WIDTH-1:0] i_wdata,
  // Read ports
  input  wire [AW-1:0]    i_raddr_a,
  output reg  [WIDTH-1:0] o_rdata_a,
  input  wire [AW-1:0]    i_raddr_b,
  output reg  [WIDTH-1:0] o_rdata_b
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  integer         k;

  always @(posedge i_clk) begin
    if (i_rst) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_reg[k] <= {WIDTH{1'b0}};
      end
      o_rdata_a <= {WIDTH{1'b0}};
      o_rdata_b <= {WIDTH{1'b0}};
    end else begin
      if (i_wr) begin
        mem_reg[i_waddr] <= i_wdata;
      end
      o_rdata_a <= mem_reg[i_raddr_a];
      o_rdata_b <= mem_reg[i_raddr_b];
    end
  end

endmodule

`default_nettype wire

// file: verif/haptic_playback_trigger_timing_bench.sv
// Purpose: Register-level tests of the playback engine
// Assumes: MS_CYCLES shortened to 4
// Notes:   Segment lengths compared as differences to a baseline run
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, (a), (b)); end end

module haptic_playback_trigger_timing_bench;
  localparam int MS = 4;
  logic       clk = 0, rst = 1, wr_s = 0, rd_s = 0, cl = 0, tbl = 0, trig = 0, done = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, amp, peak, sa, sd, rv;
  logic [6:0] wid;
  logic [2:0] mode = 0;
  logic       req, sv, sl, sr, act, cal, diag, busy;
  int         bad_count = 0, checks_done = 0, cyc = 0;
  // Counts: overdrive, sustain, negative, requests, cal, diag, busy
  int         cnt [7], base [7];

  hpt_engine #(.MS_CYCLES(MS)) i_dut (
    .i_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr_s),
    .i_reg_rd(rd_s), .o_reg_rdata(rdata), .i_mode(mode), .i_closed_loop(cl),
    .i_time_base_long(tbl), .i_trig(trig), .o_wave_req(req), .o_wave_id(wid), .i_wave_peak(peak),
    .i_seg_valid(sv), .i_seg_amp(sa), .i_seg_dur(sd), .i_seg_last(sl), .o_seg_ready(sr),
    .o_drive_amp(amp), .o_drive_active(act), .o_cal_start(cal), .o_diag_start(diag),
    .i_proc_done(done), .o_busy(busy));
  hpt_wave_lib i_lib (.i_clk(clk), .i_rst(rst), .i_wave_req(req), .i_seg_ready(sr),
    .o_wave_peak(peak), .o_seg_valid(sv), .o_seg_amp(sa), .o_seg_dur(sd), .o_seg_last(sl));

  // ****
  // Clock, monitors, tasks
  // ****
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    cnt[0] += (act === 1'b1 && amp === 8'h40);
    cnt[1] += (act === 1'b1 && amp === 8'h20);
    cnt[2] += (act === 1'b1 && amp === 8'he0);
    cnt[3] += (req === 1'b1);
    cnt[4] += (cal === 1'b1);
    cnt[5] += (diag === 1'b1);
    cnt[6] += (busy === 1'b1);
    // Whole run is well under this
    if (cyc > 30000) begin
      bad_count++;
      final_report;
    end
  end
  task final_report;
    $display("mismatches=%0d checks=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr_s = 1;
    @(posedge clk);
    #1;
    wr_s = 0;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    addr = a;
    rd_s = 1;
    @(posedge clk);
    #1;
    rd_s = 0;
    rv = rdata;
    `CHK(rv, e)
  endtask
  task clr;
    foreach (cnt[i]) cnt[i] = 0;
  endtask
  task wait_idle;
    // Engine leaves idle one edge after the fire write lands
    repeat (2) @(posedge clk);
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk);
    #1;
  endtask
  task wait_act;
    for (int n = 0; n < 500 && act !== 1'b1; n++) @(posedge clk);
    #1;
  endtask
  task play;
    clr;
    wr(8'h0c, 8'h01);
    wait_idle;
  endtask
  task do_rst;
    rst = 1;
    repeat (3) @(posedge clk);
    #1;
    rst = 0;
    rchk(8'h0c, 8'h00);
    rchk(8'h0d, 8'h00);
    rchk(8'h0e, 8'h00);
    wr(8'h04, 8'h01);
    wr(8'h05, 8'h81);
    wr(8'h06, 8'h02);
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    do_rst;
    rchk(8'h20, 8'h00);
    wr(8'h0d, 8'ha5);
    rchk(8'h0d, 8'ha5);
    wr(8'h0e, 8'h5a);
    rchk(8'h0e, 8'h5a);
    wr(8'h0d, 8'h00);
    wr(8'h0e, 8'h00);
    clr;
    wr(8'h0c, 8'h01);
    rchk(8'h0c, 8'h01);
    wait_idle;
    rchk(8'h0c, 8'h00);
    `CHK(cnt[3], 2)
    `CHK(wid, 7'h02)
    base = cnt;
    wr(8'h05, 8'h82);
    play;
    `CHK(cnt[6] - base[6], 10 * MS)
    wr(8'h05, 8'h81);
    wr(8'h0d, 8'h02);
    wr(8'h0e, 8'hff);
    play;
    `CHK(cnt[0] - base[0], 2 * 2 * MS)
    `CHK(base[1] - cnt[1], 2 * MS)
    `CHK(cnt[2], base[2])
    wr(8'h0d, 8'hfb);
    wr(8'h0e, 8'hf8);
    play;
    `CHK(cnt[0] < 3 && cnt[1] < 3, 1'b1)
    `CHK(cnt[3], 2)
    wr(8'h0d, 8'h02);
    wr(8'h0e, 8'h00);
    cl = 1;
    play;
    `CHK(cnt[0], base[0])
    cl = 0;
    wr(8'h0d, 8'h00);
    tbl = 1;
    play;
    `CHK(cnt[0] - base[0], 2 * 2 * 4 * MS)
    tbl = 0;
    wr(8'h0c, 8'hfe);
    rchk(8'h0c, 8'h00);
    wr(8'h0d, 8'h03);
    wr(8'h0c, 8'h01);
    wait_act;
    wr(8'h0c, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    `CHK({busy, act}, 2'b00)
    rchk(8'h0c, 8'h00);
    do_rst;
    for (int m = 6; m < 8; m++) begin
      mode = 3'(m);
      clr;
      wr(8'h0c, 8'h01);
      rchk(8'h0c, 8'h01);
      repeat (2) @(posedge clk);
      #1;
      `CHK({cnt[4] == 1, cnt[5] == 1, cnt[3] == 0}, (m == 7) ? 3'b101 : 3'b011)
      done = 1;
      @(posedge clk);
      #1;
      done = 0;
      rchk(8'h0c, 8'h00);
    end
    mode = 3'h3;
    wr(8'h0c, 8'h01);
    repeat (2) @(posedge clk);
    rchk(8'h0c, 8'h00);
    mode = 3'h1;
    clr;
    wr(8'h0c, 8'h01);
    rchk(8'h0c, 8'h00);
    trig = 1;
    repeat (3) @(posedge clk);
    rchk(8'h0c, 8'h01);
    wait_idle;
    `CHK(cnt[3], 2)
    rchk(8'h0c, 8'h00);
    trig = 0;
    mode = 3'h2;
    repeat (2) @(posedge clk);
    #1;
    trig = 1;
    wait_act;
    trig = 0;
    repeat (3) @(posedge clk);
    #1;
    `CHK(busy, 1'b0)
    do_rst;
    final_report;
  end
endmodule
`default_nettype wire

// file: verif/hpt_engine_properties.sv
// Purpose: Port-level checks of the playback engine
// Assumes: One clock, synchronous reset
// Notes:   Bound onto every hpt_engine instance
`timescale 1ns/1ps
`default_nettype none
`include "hpt_regs.vh"

module hpt_engine_props #(
  parameter MS_CYCLES = 10000
) (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [2:0] i_mode,
  // Library and drive
  input wire logic       o_wave_req,
  input wire logic       i_seg_valid,
  input wire logic [7:0] i_seg_amp,
  input wire logic [7:0] i_seg_dur,
  input wire logic       o_seg_ready,
  input wire logic [7:0] o_drive_amp,
  input wire logic       o_drive_active,
  input wire logic       o_cal_start,
  input wire logic       o_diag_start,
  input wire logic       o_busy
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_fire_set;
    i_reg_wr && i_reg_addr == `HPT_ADDR_FIRE && i_reg_wdata[0] && i_mode == `HPT_MODE_INT_TRIG && !o_busy;
  endsequence
  sequence s_fire_clr;
    i_reg_wr && i_reg_addr == `HPT_ADDR_FIRE && !i_reg_wdata[0] && i_mode == `HPT_MODE_INT_TRIG && o_busy;
  endsequence
  property p_launch; s_fire_set |-> ##[1:6] o_wave_req; endproperty
  a_launch: assert property (p_launch) else $error("no waveform request after fire");
  property p_abort; s_fire_clr |-> ##[1:3] !o_busy; endproperty
  a_abort: assert property (p_abort) else $error("engine kept running after clear");
  property p_unmapped;
    i_reg_rd && (i_reg_addr < `HPT_ADDR_SLOT_FIRST || i_reg_addr > `HPT_ADDR_PS_ADJ) |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_fire_rsvd; i_reg_rd && i_reg_addr == `HPT_ADDR_FIRE |=> o_reg_rdata[7:1] == 7'h00; endproperty
  a_fire_rsvd: assert property (p_fire_rsvd) else $error("fire reserved bits set");
  property p_rd_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_req_pulse; o_wave_req |=> !o_wave_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than one cycle");
  property p_cal; o_cal_start |-> i_mode == `HPT_MODE_CAL && !o_diag_start ##1 !o_cal_start; endproperty
  a_cal: assert property (p_cal) else $error("calibration start wrong");
  property p_diag; o_diag_start |-> i_mode == `HPT_MODE_DIAG ##1 !o_diag_start; endproperty
  a_diag: assert property (p_diag) else $error("diagnostic start wrong");
  property p_neg_seg;
    o_seg_ready && i_seg_valid && i_seg_amp[7] && i_seg_dur != 8'h00 |=>
      o_drive_active && o_drive_amp == $past(i_seg_amp);
  endproperty
  a_neg_seg: assert property (p_neg_seg) else $error("negative segment not driven as given");
  property p_idle; !o_busy && $past(!o_busy) |-> !o_drive_active && !o_seg_ready; endproperty
  a_idle: assert property (p_idle) else $error("drive while idle");
endmodule

bind hpt_engine hpt_engine_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_mode(i_mode),
  .o_wave_req(o_wave_req), .i_seg_valid(i_seg_valid), .i_seg_amp(i_seg_amp), .i_seg_dur(i_seg_dur),
  .o_seg_ready(o_seg_ready), .o_drive_amp(o_drive_amp), .o_drive_active(o_drive_active),
  .o_cal_start(o_cal_start), .o_diag_start(o_diag_start), .o_busy(o_busy));
`default_nettype wire

// file: verif/hpt_wave_lib.sv
// Purpose: Waveform library model feeding segments
// Assumes: Every waveform is overdrive, positive sustain, negative
// Notes:   Released segment lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module hpt_wave_lib (
  // Clock and reset
  input wire logic      i_clk,
  input wire logic      i_rst,
  // Request and handshake
  input wire logic      i_wave_req,
  input wire logic      i_seg_ready,
  // Segment
  output var logic [7:0] o_wave_peak,
  output var logic       o_seg_valid,
  output var logic [7:0] o_seg_amp,
  output var logic [7:0] o_seg_dur,
  output var logic       o_seg_last
);
  // ****
  // Segment feeder
  // ****
  logic [7:0] amp_t [0:2] = '{8'h40, 8'h20, 8'he0};
  logic [7:0] dur_t [0:2] = '{8'h02, 8'h03, 8'h01};
  initial begin
    o_wave_peak = 8'h40;
    o_seg_valid = 1'b0;
    o_seg_amp   = 8'h00;
    o_seg_dur   = 8'h00;
    o_seg_last  = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_wave_req && !i_rst) begin
        for (int k = 0; k < 3 && !i_rst; k++) begin
          #1;
          o_seg_valid = 1'b1;
          o_seg_amp   = amp_t[k];
          o_seg_dur   = dur_t[k];
          o_seg_last  = (k == 2);
          // Held until the engine takes it; a reset drops it
          do @(posedge i_clk); while (i_seg_ready !== 1'b1 && !i_rst);
        end
        #1;
        o_seg_valid = 1'b0;
        o_seg_amp   = ~o_seg_amp;
        o_seg_dur   = ~o_seg_dur;
        o_seg_last  = ~o_seg_last;
      end
    end
  end
endmodule
`default_nettype wire
